/* File: hw/ihpi_defs.svh */
// constants of the isa host pin interface: offsets, fields, responses, timing
`ifndef IHPI_DEFS_SVH
`define IHPI_DEFS_SVH
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define IHPI_CLK_MHZ       200
`define IHPI_PM_PULSE_NS   200
`define IHPI_PM_PULSE_CYC  ((`IHPI_PM_PULSE_NS * `IHPI_CLK_MHZ) / 1000)
// ----------------------------------------------------------------
// register word indices, byte address is four times the index
// ----------------------------------------------------------------
`define IHPI_R_CTRL   6'h00
`define IHPI_R_BASE   6'h01
`define IHPI_R_IRQ    6'h02
`define IHPI_R_ROUTE  6'h03
`define IHPI_R_DMA    6'h04
`define IHPI_R_GPIO   6'h05
`define IHPI_R_HOST   6'h06
`define IHPI_R_WAIT   6'h07
`define IHPI_R_PMEV   6'h08
// ----------------------------------------------------------------
// control register bits
// ----------------------------------------------------------------
`define IHPI_C_ACPI    0
`define IHPI_C_SMGTEN  1
`define IHPI_C_SERIAL  2
`define IHPI_C_CLKSEL  3
`define IHPI_C_PINB    4
`define IHPI_C_PINA    5
`define IHPI_C_EPP     6
`define IHPI_C_ECP     7
// ----------------------------------------------------------------
// routing, serial slots, bus answers
// ----------------------------------------------------------------
`define IHPI_RT_EN        3
`define IHPI_ROUTE_PIN    4'h0
`define IHPI_ROUTE_SER    4'h9
`define IHPI_SER_SLOT     4'h8
`define IHPI_SLOT_LAST    4'hE
`define IHPI_RESP_OKAY    2'h0
`define IHPI_RESP_DECERR  2'h3
`endif

/* File: hw/ihpi_pkg.sv */
// types of the isa host pin interface
package ihpi_pkg;
    // serial interrupt frame states
    typedef enum logic [1:0] {
        SQ_IDLE  = 2'b00,
        SQ_START = 2'b01,
        SQ_SLOT  = 2'b10
    } ihpi_sq_e;

    // pins that cross into the clock domain
    typedef struct packed {
        logic       cs_n;
        logic       aen;
        logic       ior_n;
        logic       iow_n;
        logic       ma;
        logic [9:0] addr;
        logic [7:0] data;
        logic [2:0] dack_n;
        logic       endc;
        logic       rin;
        logic [3:0] irq_i;
    } ihpi_pins_s;

    typedef struct packed {
        ihpi_pins_s s1;
        ihpi_pins_s s2;
        logic       mr1;
        logic       mr2;
    } ihpi_sync_s;

    typedef struct packed {
        ihpi_sync_s  sy;
        logic        ior_p, iow_p, pc_p;
        logic [7:0]  ctrl, route, reply, hwdata, wl, wait_n, wcnt, d_o, irq_o, irq_oe;
        logic [10:0] base;
        logic [14:0] irq_src;
        logic [2:0]  drq, endd;
        logic [1:0]  gpo, gpe;
        logic        hwflag, rdy_oe, d_oe;
        logic [5:0]  pcnt;
        logic        pacpi, psmgt, sctl_oe, smgt_oe;
        logic [3:0]  proute, sq_slot;
        ihpi_sq_e    sq_st;
        logic [1:0]  sq_ph;
        logic        sq_o, sq_oe;
        logic        aw_got, w_got, awrdy, wrdy, bvalid, arrdy, rvalid;
        logic [5:0]  awa;
        logic [31:0] wd, rdata;
        logic [3:0]  wstb;
        logic [1:0]  bresp, rresp;
    } ihpi_state_s;
endpackage : ihpi_pkg

/* File: hw/ihpi_top.sv */
// isa host pin interface: host strobes, dma, interrupt pins, power pulses
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "ihpi_defs.svh"
// Contract
// - master reset pin is active high and resets the block
// - host cycles are answered only while chip select is low
// - data moves over an eight bit two-way bus, bits 0 to 7
// - upper address line joins the decode only in extended capabilities mode
// - enhanced port mode pulls channel ready low to stretch host cycles
// - pin A is interrupt A when select bit 5 is 0, io one otherwise
// - pin B is interrupt B when select bit 4 is 0, io zero otherwise
// - serial mode turns pin H into the serial interrupt line
// - serial mode uses pin G as the pci clock input
// - eight parallel lines, fifteen serial slots, three dma channels
// - terminal count ends the acknowledged dma transfer
// - routed interrupt input is steered onto a chosen interrupt line
// - acpi mode: each event routed to the control pin pulls system control line low 200ns
// - legacy mode: each event pulls management line low 200ns
// - management line is driven only for events taken while its enable bit is set
// - acpi status goes to control pin, serial line or a parallel line
// - clock frequency select bit is kept for software to match the clock
module ihpi_top
    import ihpi_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        NRST,
    input  wire logic        MASTER_RESET_IN,
    input  wire logic        CS_N,
    input  wire logic        AEN,
    input  wire logic        IOR_N,
    input  wire logic        IOW_N,
    input  wire logic [9:0]  ADDR,
    input  wire logic        UPPER_ADDRESS_LINE,
    input  wire logic [7:0]  D_I,
    output wire logic [7:0]  D_O,
    output wire logic        D_OE,
    output wire logic        CHANNEL_READY_O,
    output wire logic        CHANNEL_READY_OE,
    output wire logic        DMA_REQUEST_A,
    output wire logic        DMA_REQUEST_B,
    output wire logic        DMA_REQUEST_C,
    input  wire logic        DMA_ACK_A_N,
    input  wire logic        DMA_ACK_B_N,
    input  wire logic        DMA_ACK_C_N,
    input  wire logic        TRANSFER_END_COUNT,
    input  wire logic        ROUTED_INTERRUPT_INPUT,
    input  wire logic [3:0]  IRQ_I,
    output wire logic [7:0]  IRQ_O,
    output wire logic [7:0]  IRQ_OE,
    output wire logic        SYSTEM_CONTROL_INTERRUPT_N_O,
    output wire logic        SYSTEM_CONTROL_INTERRUPT_N_OE,
    output wire logic        SYSTEM_MANAGEMENT_INTERRUPT_N_O,
    output wire logic        SYSTEM_MANAGEMENT_INTERRUPT_N_OE,
    input  wire logic [7:0]  AWADDR,
    input  wire logic        AWVALID,
    output wire logic        AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output wire logic        WREADY,
    output wire logic [1:0]  BRESP,
    output wire logic        BVALID,
    input  wire logic        BREADY,
    input  wire logic [7:0]  ARADDR,
    input  wire logic        ARVALID,
    output wire logic        ARREADY,
    output wire logic [31:0] RDATA,
    output wire logic [1:0]  RRESP,
    output wire logic        RVALID,
    input  wire logic        RREADY
);
    ihpi_state_s r, next_r, rs;
    ihpi_pins_s  pins, p;
    logic        hit, sel, wr_end, st_start, do_wr, pr, pon, sv;
    logic [31:0] wm, wv, w1;
    logic [7:0]  lv;

    // ----------------------------------------------------------------
    // register decode helpers
    // ----------------------------------------------------------------
    function automatic logic mapped(input logic [5:0] a);
        mapped = (a <= `IHPI_R_PMEV);
    endfunction : mapped

    function automatic logic [31:0] rd_reg(input logic [5:0] a);
        case (a)
            `IHPI_R_CTRL:  rd_reg = {24'h000000, r.ctrl};
            `IHPI_R_BASE:  rd_reg = {21'h000000, r.base};
            `IHPI_R_IRQ:   rd_reg = {17'h00000, r.irq_src};
            `IHPI_R_ROUTE: rd_reg = {24'h000000, r.route};
            `IHPI_R_DMA:   rd_reg = {25'h0000000, r.endd, 1'b0, r.drq};
            `IHPI_R_GPIO:  rd_reg = {26'h0000000, r.sy.s2.irq_i[0], r.sy.s2.irq_i[1],
                                     r.gpe, r.gpo};
            `IHPI_R_HOST:  rd_reg = {15'h0000, r.hwflag, r.hwdata, r.reply};
            `IHPI_R_WAIT:  rd_reg = {24'h000000, r.wait_n};
            `IHPI_R_PMEV:  rd_reg = {31'h00000000, (r.pcnt != 6'h00)};
            default:       rd_reg = 32'h00000000;
        endcase
    endfunction : rd_reg

    // pins gathered for the synchroniser
    assign pins = '{cs_n: CS_N, aen: AEN, ior_n: IOR_N, iow_n: IOW_N,
                    ma: UPPER_ADDRESS_LINE, addr: ADDR, data: D_I,
                    dack_n: {DMA_ACK_C_N, DMA_ACK_B_N, DMA_ACK_A_N},
                    endc: TRANSFER_END_COUNT, rin: ROUTED_INTERRUPT_INPUT, irq_i: IRQ_I};

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_r = r;
        rs     = '0;
        p      = r.sy.s2;
        // two flops on every pin before use
        next_r.sy.s1 = pins;
        next_r.sy.s2 = r.sy.s1;
        next_r.sy.mr1 = MASTER_RESET_IN;
        next_r.sy.mr2 = r.sy.mr1;
        next_r.ior_p = p.ior_n;
        next_r.iow_p = p.iow_n;
        next_r.pc_p  = p.irq_i[2];

        // host decode; the upper line only counts in ecp mode
        hit = r.ctrl[`IHPI_C_ECP] ? ({p.ma, p.addr} == r.base)
                                  : (p.addr == r.base[9:0]);
        sel = !p.cs_n && !p.aen && hit;
        next_r.d_oe = sel && !p.ior_n;
        next_r.d_o  = r.reply;
        // latch data while the write strobe is low, skew at its end is unsafe
        if (!p.iow_n) begin
            next_r.wl = p.data;
        end
        wr_end   = sel && !r.iow_p && p.iow_n;
        st_start = sel && ((r.ior_p && !p.ior_n) || (r.iow_p && !p.iow_n));
        if (wr_end) begin
            next_r.hwdata = r.wl;
        end

        // cycle stretch in enhanced port mode
        if (r.wcnt != 8'h00) begin
            next_r.wcnt = r.wcnt - 8'h01;
        end
        if (st_start && r.ctrl[`IHPI_C_EPP]) begin
            next_r.wcnt = r.wait_n;
        end
        if (!r.ctrl[`IHPI_C_EPP]) begin
            next_r.wcnt = 8'h00;
        end
        next_r.rdy_oe = (next_r.wcnt != 8'h00);

        // register bus: address and data taken in either order
        if (AWVALID && r.awrdy) begin
            next_r.aw_got = 1'b1;
            next_r.awa    = AWADDR[7:2];
        end
        if (WVALID && r.wrdy) begin
            next_r.w_got = 1'b1;
            next_r.wd    = WDATA;
            next_r.wstb  = WSTRB;
        end
        do_wr = r.aw_got && r.w_got && !r.bvalid;
        wm = {{8{r.wstb[3]}}, {8{r.wstb[2]}}, {8{r.wstb[1]}}, {8{r.wstb[0]}}};
        wv = (rd_reg(r.awa) & ~wm) | (r.wd & wm);
        w1 = r.wd & wm;
        if (r.pcnt != 6'h00) begin
            next_r.pcnt = r.pcnt - 6'h01;
        end
        // terminal count drops the request of the acknowledged channel
        for (int i = 0; i < 3; i++) begin
            if (r.drq[i] && p.endc && !p.dack_n[i]) begin
                next_r.drq[i] = 1'b0;
            end
        end
        if (do_wr) begin
            next_r.aw_got = 1'b0;
            next_r.w_got  = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp  = mapped(r.awa) ? `IHPI_RESP_OKAY : `IHPI_RESP_DECERR;
            case (r.awa)
                `IHPI_R_CTRL:  next_r.ctrl    = wv[7:0];
                `IHPI_R_BASE:  next_r.base    = wv[10:0];
                `IHPI_R_IRQ:   next_r.irq_src = wv[14:0];
                `IHPI_R_ROUTE: next_r.route   = wv[7:0];
                `IHPI_R_DMA: begin
                    next_r.drq  = next_r.drq | w1[2:0];
                    next_r.endd = r.endd & ~w1[6:4];
                end
                `IHPI_R_GPIO: begin
                    next_r.gpo = wv[1:0];
                    next_r.gpe = wv[3:2];
                end
                `IHPI_R_HOST: begin
                    next_r.reply  = wv[7:0];
                    next_r.hwflag = r.hwflag & ~w1[16];
                end
                `IHPI_R_WAIT:  next_r.wait_n  = wv[7:0];
                `IHPI_R_PMEV: begin
                    // events during a running pulse are dropped, not queued
                    if (w1[0] && r.pcnt == 6'h00) begin
                        next_r.pcnt   = 6'(`IHPI_PM_PULSE_CYC);
                        next_r.pacpi  = r.ctrl[`IHPI_C_ACPI];
                        next_r.proute = r.route[7:4];
                        next_r.psmgt  = !r.ctrl[`IHPI_C_ACPI] && r.ctrl[`IHPI_C_SMGTEN];
                    end
                end
                default: begin
                end
            endcase
        end
        // hardware sets win over software clears
        for (int i = 0; i < 3; i++) begin
            if (r.drq[i] && p.endc && !p.dack_n[i]) begin
                next_r.endd[i] = 1'b1;
            end
        end
        if (wr_end) begin
            next_r.hwflag = 1'b1;
        end
        if (r.bvalid && BREADY) begin
            next_r.bvalid = 1'b0;
        end
        next_r.awrdy = !next_r.aw_got && !next_r.bvalid;
        next_r.wrdy  = !next_r.w_got && !next_r.bvalid;
        if (ARVALID && r.arrdy) begin
            next_r.rvalid = 1'b1;
            next_r.rdata  = rd_reg(ARADDR[7:2]);
            next_r.rresp  = mapped(ARADDR[7:2]) ? `IHPI_RESP_OKAY : `IHPI_RESP_DECERR;
        end else if (r.rvalid && RREADY) begin
            next_r.rvalid = 1'b0;
        end
        next_r.arrdy = !next_r.rvalid;

        // power management pulses
        pon = (next_r.pcnt != 6'h00);
        next_r.sctl_oe = pon && next_r.pacpi && next_r.proute == `IHPI_ROUTE_PIN;
        next_r.smgt_oe = pon && next_r.psmgt;

        // parallel lines: sources, routed input and acpi status
        pon = (r.pcnt != 6'h00);
        for (int i = 0; i < 8; i++) begin
            lv[i] = r.irq_src[i] | (r.route[`IHPI_RT_EN] && r.route[2:0] == 3'(i) && p.rin)
                  | (pon && r.pacpi && r.proute == 4'(i + 1));
        end
        next_r.irq_o  = lv;
        next_r.irq_oe = 8'hFF;
        if (r.ctrl[`IHPI_C_PINA]) begin
            next_r.irq_o[0]  = r.gpo[1];
            next_r.irq_oe[0] = r.gpe[1];
        end
        if (r.ctrl[`IHPI_C_PINB]) begin
            next_r.irq_o[1]  = r.gpo[0];
            next_r.irq_oe[1] = r.gpe[0];
        end

        // serial interrupt frames, clocked by pci clock edges seen on pin G
        pr = p.irq_i[2] && !r.pc_p;
        sv = r.irq_src[r.sq_slot] | (pon && r.pacpi && r.proute == `IHPI_ROUTE_SER
                                     && r.sq_slot == `IHPI_SER_SLOT);
        if (!r.ctrl[`IHPI_C_SERIAL]) begin
            next_r.sq_st = SQ_IDLE;
            next_r.sq_oe = 1'b0;
            next_r.sq_ph = 2'h0;
        end else if (pr) begin
            case (r.sq_st)
                SQ_IDLE: begin
                    if (!p.irq_i[3]) begin
                        next_r.sq_st = SQ_START;
                    end
                end
                SQ_START: begin
                    if (p.irq_i[3]) begin
                        next_r.sq_st   = SQ_SLOT;
                        next_r.sq_slot = 4'h0;
                        next_r.sq_ph   = 2'h0;
                    end
                end
                SQ_SLOT: begin
                    // sample low, recover high, then turn the line around
                    case (r.sq_ph)
                        2'h0: begin
                            next_r.sq_oe = sv;
                            next_r.sq_o  = 1'b0;
                            next_r.sq_ph = 2'h1;
                        end
                        2'h1: begin
                            next_r.sq_o  = 1'b1;
                            next_r.sq_ph = 2'h2;
                        end
                        default: begin
                            next_r.sq_oe = 1'b0;
                            next_r.sq_ph = 2'h0;
                            if (r.sq_slot == `IHPI_SLOT_LAST) begin
                                next_r.sq_st = SQ_IDLE;
                            end else begin
                                next_r.sq_slot = r.sq_slot + 4'h1;
                            end
                        end
                    endcase
                end
                default: next_r.sq_st = SQ_IDLE;
            endcase
        end
        if (r.ctrl[`IHPI_C_SERIAL]) begin
            next_r.irq_oe[6] = 1'b0;
            next_r.irq_o[6]  = 1'b0;
            next_r.irq_oe[7] = next_r.sq_oe;
            next_r.irq_o[7]  = next_r.sq_o;
        end

        // master reset pin clears all but the pin and master reset synchronisers
        if (r.sy.mr2) begin
            rs.sy  = next_r.sy;
            next_r = rs;
        end
    end

    // state register
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // outputs; open-drain pins only ever pull low
    assign D_O                              = r.d_o;
    assign D_OE                             = r.d_oe;
    assign CHANNEL_READY_O                  = 1'b0;
    assign CHANNEL_READY_OE                 = r.rdy_oe;
    assign DMA_REQUEST_A                    = r.drq[0];
    assign DMA_REQUEST_B                    = r.drq[1];
    assign DMA_REQUEST_C                    = r.drq[2];
    assign IRQ_O                            = r.irq_o;
    assign IRQ_OE                           = r.irq_oe;
    assign SYSTEM_CONTROL_INTERRUPT_N_O     = 1'b0;
    assign SYSTEM_CONTROL_INTERRUPT_N_OE    = r.sctl_oe;
    assign SYSTEM_MANAGEMENT_INTERRUPT_N_O  = 1'b0;
    assign SYSTEM_MANAGEMENT_INTERRUPT_N_OE = r.smgt_oe;
    assign AWREADY                          = r.awrdy;
    assign WREADY                           = r.wrdy;
    assign BRESP                            = r.bresp;
    assign BVALID                           = r.bvalid;
    assign ARREADY                          = r.arrdy;
    assign RDATA                            = r.rdata;
    assign RRESP                            = r.rresp;
    assign RVALID                           = r.rvalid;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    mr_reset_a: assert property (r.sy.mr2 |=> (r.drq == 3'h0 && r.ctrl == 8'h00))
        else $error("master reset did not clear state");
    read_drive_a: assert property (disable iff (!NRST || r.sy.mr2)
        r.d_oe |-> $past(sel) && $past(!p.ior_n)) else $error("data driven outside read");
    dma_ignore_a: assert property (p.aen |=> !r.d_oe)
        else $error("data driven while address enable high");
    pin_a_mode_a: assert property ((r.ctrl[5] && !r.sy.mr2) |=> r.irq_oe[0] == $past(r.gpe[1]))
        else $error("pin A not in io mode");
    pin_b_mode_a: assert property ((!r.ctrl[4] && !r.sy.mr2) |=> r.irq_oe[1])
        else $error("pin B not driving interrupt");
    ctl_pulse_a: assert property (disable iff (!NRST || r.sy.mr2)
        $rose(r.sctl_oe) |-> ##39 r.sctl_oe ##1 !r.sctl_oe) else $error("pulse width wrong");
    mgt_gate_a: assert property ($rose(r.smgt_oe) |-> $past(r.ctrl[1]))
        else $error("management line without enable");
    end_count_a: assert property (disable iff (!NRST || r.sy.mr2)
        (r.drq[0] && p.endc && !p.dack_n[0]) |=> r.endd[0]) else $error("count not flagged");
    epp_stretch_a: assert property (r.rdy_oe |-> $past(r.ctrl[6]))
        else $error("ready pulled outside epp mode");

    ctl_pulse_c: cover property ($rose(r.sctl_oe));
    ser_slot_c:  cover property (r.sq_st == SQ_SLOT && r.sq_oe && !r.sq_o);
    host_wr_c:   cover property (wr_end);
    bus_wr_c:    cover property (do_wr);
endmodule : ihpi_top

/* File: tb/ihpi_host_model.sv */
// isa host model driving the host pins of the block
`timescale 1ns/10ps
module ihpi_host_model
    import ihpi_pkg::*;
(
    input  wire logic       CLK,
    output logic            CS_N,
    output logic            AEN,
    output logic            IOR_N,
    output logic            IOW_N,
    output logic [9:0]      ADDR,
    output logic            UPPER_ADDRESS_LINE,
    output logic [7:0]      D_I,
    input  wire logic [7:0] D_O,
    input  wire logic       D_OE
);
    // idle bus: not selected, strobes high
    initial begin
        {CS_N, AEN, IOR_N, IOW_N} = 4'hB;
        {UPPER_ADDRESS_LINE, ADDR} = 11'h000;
        D_I = 8'hFF;
    end
    // one cycle, strobes low six clocks and high six, well over the three needed
    task automatic cyc(input logic r, input logic sel, input logic dma, input logic [10:0] a,
                       input logic [7:0] wd, output logic [7:0] got, output logic drv);
        @(posedge CLK);
        CS_N <= !sel;
        AEN <= dma;
        {UPPER_ADDRESS_LINE, ADDR} <= a;
        D_I <= wd;
        @(posedge CLK);
        if (r) IOR_N <= 1'b0; else IOW_N <= 1'b0;
        repeat (6) @(posedge CLK);
        drv = D_OE;
        got = D_O;
        {IOR_N, IOW_N} <= 2'b11;
        repeat (6) @(posedge CLK);
        CS_N <= 1'b1;
        D_I <= ~wd; // released bus, show the inverse rather than a stale value
    endtask : cyc
endmodule : ihpi_host_model

/* File: tb/tb_top.sv */
// self-checking bench for the isa host pin interface
`timescale 1ns/10ps
`include "ihpi_defs.svh"
module tb_top
    import ihpi_pkg::*;
;
logic CLK, NRST, MASTER_RESET_IN, CS_N, AEN, IOR_N, IOW_N, UPPER_ADDRESS_LINE, D_OE, v;
logic [9:0] ADDR; logic [7:0] D_I, D_O, IRQ_O, IRQ_OE, AWADDR, ARADDR, b;
logic CHANNEL_READY_O, CHANNEL_READY_OE, DMA_REQUEST_A, DMA_REQUEST_B, DMA_REQUEST_C;
logic DMA_ACK_A_N, DMA_ACK_B_N, DMA_ACK_C_N, TRANSFER_END_COUNT, ROUTED_INTERRUPT_INPUT;
logic [3:0] IRQ_I, WSTRB; logic [31:0] WDATA, RDATA, rd; logic [1:0] BRESP, RRESP, rs;
logic SYSTEM_CONTROL_INTERRUPT_N_O, SYSTEM_CONTROL_INTERRUPT_N_OE;
logic SYSTEM_MANAGEMENT_INTERRUPT_N_O, SYSTEM_MANAGEMENT_INTERRUPT_N_OE;
logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
int n_mismatch = 0, check_count = 0, sc_n = 0, sm_n = 0, rdy_n = 0, s0, m0;
ihpi_top DUT (.*);
ihpi_host_model host (.*);
// ----------------------------------------------------------------
// clock, pulse counters, watchdog
// ----------------------------------------------------------------
initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
end
always @(posedge CLK) begin
    sc_n += SYSTEM_CONTROL_INTERRUPT_N_OE;
    sm_n += SYSTEM_MANAGEMENT_INTERRUPT_N_OE;
    rdy_n += CHANNEL_READY_OE;
end
initial begin
    repeat (20000) @(posedge CLK);
    n_mismatch++;
    wrap_up();
end
// ----------------------------------------------------------------
// bus tasks and compare
// ----------------------------------------------------------------
task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
        n_mismatch++;
        $display("ERROR t=%0t got %h expected %h", $time, g, e);
    end
endtask : chk
// address and data offered together, each dropped once taken
task automatic axw(input logic [5:0] i, input logic [31:0] d);
    @(posedge CLK);
    AWADDR <= {i, 2'b00}; WDATA <= d; AWVALID <= 1'b1; WVALID <= 1'b1; BREADY <= 1'b1;
    fork
        begin do @(posedge CLK); while (!AWREADY); AWVALID <= 1'b0; end
        begin do @(posedge CLK); while (!WREADY); WVALID <= 1'b0; end
    join
    do @(posedge CLK); while (!BVALID);
    chk(BRESP, (i > 6'h08) ? `IHPI_RESP_DECERR : `IHPI_RESP_OKAY);
    BREADY <= 1'b0;
endtask : axw
task automatic axr(input logic [5:0] i, output logic [31:0] d, output logic [1:0] r);
    @(posedge CLK);
    ARADDR <= {i, 2'b00}; ARVALID <= 1'b1; RREADY <= 1'b1;
    do @(posedge CLK); while (!ARREADY);
    ARVALID <= 1'b0;
    do @(posedge CLK); while (!RVALID);
    d = RDATA; r = RRESP; RREADY <= 1'b0;
endtask : axr
// one pci clock period on pin G, host level of the serial line on pin H
task automatic pci(input logic h);
    IRQ_I[3] <= h; IRQ_I[2] <= 1'b1;
    repeat (4) @(posedge CLK);
    IRQ_I[2] <= 1'b0;
    repeat (4) @(posedge CLK);
endtask : pci
// one event, pulse length counted on both lines; snapshot taken before the event write
task automatic pm(input logic [31:0] c, input int es, input int em);
    axw(`IHPI_R_CTRL, c);
    s0 = sc_n; m0 = sm_n;
    axw(`IHPI_R_PMEV, 32'h1);
    repeat (60) @(posedge CLK);
    chk(sc_n - s0, es);
    chk(sm_n - m0, em);
endtask : pm
task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
        $display("RESULT: PASS");
    else
        $display("RESULT: FAIL");
    $finish;
endtask : wrap_up
// ----------------------------------------------------------------
// main sequence
// ----------------------------------------------------------------
initial begin
    {NRST, MASTER_RESET_IN, AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
    {AWADDR, ARADDR, WDATA, IRQ_I, TRANSFER_END_COUNT, ROUTED_INTERRUPT_INPUT} = '0;
    {DMA_ACK_A_N, DMA_ACK_B_N, DMA_ACK_C_N, WSTRB} = 7'h7F;
    repeat (10) @(posedge CLK);
    NRST <= 1'b1;
    repeat (2) @(posedge CLK);
    axr(`IHPI_R_CTRL, rd, rs); chk(rd, 0);
    axr(6'h0A, rd, rs); chk(rs, `IHPI_RESP_DECERR); chk(rd, 0);
    axw(6'h0A, 32'h1);
    axw(`IHPI_R_BASE, 32'h2F8); axw(`IHPI_R_HOST, 32'hA5);
    host.cyc(1'b1, 1'b1, 1'b0, 11'h2F8, 8'h00, b, v); chk({v, b}, 9'h1A5);
    host.cyc(1'b1, 1'b0, 1'b0, 11'h2F8, 8'h00, b, v); chk(v, 0);
    host.cyc(1'b1, 1'b1, 1'b1, 11'h2F8, 8'h00, b, v); chk(v, 0);
    host.cyc(1'b1, 1'b1, 1'b0, 11'h2F9, 8'h00, b, v); chk(v, 0);
    host.cyc(1'b0, 1'b1, 1'b0, 11'h2F8, 8'h3C, b, v);
    axr(`IHPI_R_HOST, rd, rs); chk(rd, 32'h13CA5);
    axw(`IHPI_R_CTRL, 32'h80); axw(`IHPI_R_BASE, 32'h6F8);
    host.cyc(1'b1, 1'b1, 1'b0, 11'h2F8, 8'h00, b, v); chk(v, 0);
    host.cyc(1'b1, 1'b1, 1'b0, 11'h6F8, 8'h00, b, v); chk(v, 1);
    // epp: ready pulled for the programmed wait count; low base bits still match
    axw(`IHPI_R_CTRL, 32'h40); axw(`IHPI_R_WAIT, 32'h5);
    s0 = rdy_n;
    host.cyc(1'b1, 1'b1, 1'b0, 11'h2F8, 8'h00, b, v); chk(v, 1);
    chk(rdy_n - s0, 5);
    axw(`IHPI_R_IRQ, 32'h3); axw(`IHPI_R_GPIO, 32'h1); axw(`IHPI_R_CTRL, 32'h30);
    repeat (3) @(posedge CLK);
    chk({IRQ_OE[1:0], IRQ_O[1:0]}, 4'b0010);
    axw(`IHPI_R_CTRL, 32'h0);
    repeat (3) @(posedge CLK);
    chk({IRQ_OE[1:0], IRQ_O[1:0]}, 4'b1111);
    axw(`IHPI_R_ROUTE, 32'h0A);
    ROUTED_INTERRUPT_INPUT <= 1'b1;
    repeat (5) @(posedge CLK);
    chk(IRQ_O[2], 1);
    axw(`IHPI_R_DMA, 32'h7);
    repeat (2) @(posedge CLK);
    chk({DMA_REQUEST_C, DMA_REQUEST_B, DMA_REQUEST_A}, 3'b111);
    DMA_ACK_A_N <= 1'b0; TRANSFER_END_COUNT <= 1'b1;
    repeat (5) @(posedge CLK);
    {DMA_ACK_A_N, TRANSFER_END_COUNT} <= 2'b10;
    axr(`IHPI_R_DMA, rd, rs); chk(rd, 32'h16);
    pm(32'h1, 40, 0);
    chk(SYSTEM_CONTROL_INTERRUPT_N_O, 0);
    pm(32'h0, 0, 0);
    pm(32'h2, 0, 40);
    axw(`IHPI_R_CTRL, 32'h8); axr(`IHPI_R_CTRL, rd, rs); chk(rd, 32'h8);
    // serial frame: start, then slot 0 carries source 0; pin G is only listened to
    axw(`IHPI_R_CTRL, 32'h4);
    repeat (3) @(posedge CLK);
    chk(IRQ_OE[7:6], 2'b00);
    pci(1'b0); pci(1'b1); pci(1'b1);
    chk({IRQ_OE[7], IRQ_O[7]}, 2'b10);
    MASTER_RESET_IN <= 1'b1;
    repeat (4) @(posedge CLK);
    MASTER_RESET_IN <= 1'b0;
    repeat (3) @(posedge CLK);
    axr(`IHPI_R_CTRL, rd, rs); chk(rd, 0); chk(DMA_REQUEST_B, 0);
    wrap_up();
end
endmodule : tb_top
